// *** hw/dpd_playback.sv ***
// playback digital path: serial capture, volume, soft mute, limiter,
// zero-run mute and a multi-level sigma-delta modulator
// assumes serial pins come from outside the clock domain; register port is synchronous
`timescale 1ns/1ps
`default_nettype none

// Operation
// - volume attenuates half dB per code, zero mutes
// - gain spans -127 to 0 dB, reset unity
// - filters and converter run only when powered
// - samples flow volume, limiter, then modulator
// - soft mute ramps down, release ramps back
// - full 24-bit path into multi-bit modulator
// - output phase inverts when invert set
// - 1024 zero samples in a row mute
// - first non-zero sample releases, restarts count
// - zero-run mute enable resets to off
// - above upper threshold, gain drops at attack rate
// - boost zero leaves quiet signals untouched
// - below lower threshold, gain recovers at decay
// - thresholds sit half dB either side
// - limiter runs only with limiter on bit
// - threshold codes map to -1 through -6 dB
// - rate codes double per step, decay resets 6ms
// - boost 0 to 12 dB, also standalone
module dpd_playback
	import dpd_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// register port
	input  wire dpd_pkg::dpd_reg_req_s reg_req,
	input  wire logic [6:0]            reg_read_addr,
	output logic [8:0]                 reg_rdata,
	// serial sample pins
	input  wire dpd_pkg::dpd_serial_s  serial_pins,
	// converter side
	output logic [4:0]                 modulator_level,
	output logic                       zero_run_mute,
	output logic                       converter_active
);
	import dpd_pkg::*;

	dpd_state_s        st;
	dpd_state_s        next_st;
	logic              bclk_rise;
	logic              frame_rise;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic [23:0]       fifo_out_data;
	logic              tick;
	logic [23:0]       in_sample;
	logic [3:0]        boost_c;
	logic [2:0]        thresh_c;
	logic [10:0]       tot_att;
	logic [10:0]       shift_amt;
	logic [3:0]        mant_idx;
	logic signed [41:0] product;
	logic signed [41:0] scaled;
	logic [23:0]       gained;
	logic [23:0]       out_mag;
	logic [23:0]       upper_th;
	logic [23:0]       lower_th;
	logic [3:0]        atk_code;
	logic [3:0]        dcy_code;
	logic [15:0]       atk_period;
	logic [15:0]       dcy_period;
	logic [23:0]       polar;
	logic [24:0]       mod_sum;

	// ==========================================================
	// buffer
	dpd_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (st.cap == CAP_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (st.shreg),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ==========================================================
	// edges and sample tick
	// edges read only the second and third sync stages
	assign bclk_rise      = st.bclk_sync[1] && !st.bclk_sync[2];
	assign frame_rise     = st.fs_sync[1] && !st.fs_sync[2];
	assign tick           = frame_rise && st.power_on;
	assign fifo_out_ready = tick;
	// an empty buffer plays silence
	assign in_sample      = fifo_out_valid ? fifo_out_data : 24'h000000;

	// ==========================================================
	// gain
	assign boost_c   = (st.boost > BOOST_MAX) ? BOOST_MAX : st.boost;
	assign tot_att   = 11'(8'hff - st.volume) + 11'(st.soft_att) + 11'(st.lim_att) +
		11'({BOOST_MAX - boost_c, 1'b0});
	assign shift_amt = tot_att / STEPS_PER_6DB;
	assign mant_idx  = 4'(tot_att % STEPS_PER_6DB);
	assign product   = 42'(signed'(in_sample)) * 42'(signed'({1'b0, MANT_TABLE[mant_idx]}));

	always_comb begin
		scaled = '0;
		if (shift_amt < 11'd32) begin
			scaled = product >>> (GAIN_FRAC - BOOST_SHIFT + 32'(shift_amt));
		end
		if (st.volume == 8'h00 || st.soft_att == SOFT_MAX) begin
			gained = 24'h000000;
		end else if (scaled > 42'sh7fffff) begin
			gained = 24'h7fffff;
		end else if (scaled < -42'sh800000) begin
			gained = 24'h800000;
		end else begin
			gained = scaled[23:0];
		end
	end

	// ==========================================================
	// limiter thresholds and rates
	assign out_mag    = st.out_sample[23] ? 24'(-st.out_sample) : st.out_sample;
	assign thresh_c   = (st.thresh > THRESH_MAX) ? THRESH_MAX : st.thresh;
	assign upper_th   = THRESH_TABLE[thresh_c];
	assign lower_th   = THRESH_TABLE[thresh_c + 3'd1];
	assign atk_code   = (st.attack > RATE_CODE_MAX) ? RATE_CODE_MAX : st.attack;
	assign dcy_code   = (st.decay > RATE_CODE_MAX) ? RATE_CODE_MAX : st.decay;

	always_comb begin
		// widened first: the slowest decay code overflows sixteen bits before the shift back
		atk_period = 16'((20'(ATK_STEP_Q4) << atk_code) >> 4);
		dcy_period = 16'((20'(DCY_STEP_Q4) << dcy_code) >> 4);
		if (atk_period == 16'h0000) begin
			atk_period = 16'h0001;
		end
		if (dcy_period == 16'h0000) begin
			dcy_period = 16'h0001;
		end
	end

	// ==========================================================
	// modulator input
	// zero-order hold between samples stands in for interpolation
	always_comb begin
		polar = st.out_sample;
		if (st.phase_inv) begin
			polar = (st.out_sample == 24'h800000) ? 24'h7fffff : 24'(-st.out_sample);
		end
	end
	assign mod_sum = 25'({~polar[23], polar[22:0]}) + 25'(st.mod_acc);

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		next_st.bclk_sync = {st.bclk_sync[1:0], serial_pins.bit_clock};
		next_st.fs_sync   = {st.fs_sync[1:0], serial_pins.frame_sync};
		next_st.data_sync = {st.data_sync[0], serial_pins.data};

		// register writes
		if (reg_req.write) begin
			unique case (reg_req.addr)
				ADDR_POWER3: begin
					next_st.power_on = reg_req.wdata[POWER_ON_BIT];
				end
				ADDR_CONV_CTRL: begin
					next_st.soft_req  = reg_req.wdata[SOFT_MUTE_BIT];
					next_st.zero_en   = reg_req.wdata[ZERO_MUTE_BIT];
					next_st.phase_inv = reg_req.wdata[PHASE_INV_BIT];
				end
				ADDR_VOLUME: begin
					next_st.volume = reg_req.wdata[7:0];
				end
				ADDR_LIM_CTRL1: begin
					next_st.limiter_on = reg_req.wdata[LIMITER_ON_BIT];
					next_st.decay      = reg_req.wdata[DECAY_LSB +: 4];
					next_st.attack     = reg_req.wdata[ATTACK_LSB +: 4];
				end
				ADDR_LIM_CTRL2: begin
					next_st.thresh = reg_req.wdata[THRESH_LSB +: 3];
					next_st.boost  = reg_req.wdata[BOOST_LSB +: 4];
				end
				default: begin
				end
			endcase
		end

		// register read-back
		unique case (reg_read_addr)
			ADDR_POWER3:    next_st.rdata = 9'({st.power_on});
			ADDR_CONV_CTRL: next_st.rdata = 9'(({8'h00, st.soft_req} << SOFT_MUTE_BIT) |
				({8'h00, st.zero_en} << ZERO_MUTE_BIT) | ({8'h00, st.phase_inv} << PHASE_INV_BIT));
			ADDR_VOLUME:    next_st.rdata = {1'b0, st.volume};
			ADDR_LIM_CTRL1: next_st.rdata = {st.limiter_on, st.decay, st.attack};
			ADDR_LIM_CTRL2: next_st.rdata = {2'b00, st.thresh, st.boost};
			ADDR_STATUS:    next_st.rdata = {5'h00, st.active, st.lim_att != 6'd0,
				st.soft_att == SOFT_MAX, st.zero_mute};
			default:        next_st.rdata = 9'h000;
		endcase

		// serial capture, msb first after a frame edge that arrives while idle and powered
		unique case (st.cap)
			CAP_IDLE: begin
				if (frame_rise && st.power_on) begin
					next_st.cap     = CAP_SHIFT;
					next_st.bit_cnt = 5'd0;
				end
			end
			CAP_SHIFT: begin
				if (bclk_rise) begin
					next_st.shreg   = {st.shreg[22:0], st.data_sync[1]};
					next_st.bit_cnt = st.bit_cnt + 5'd1;
					if (st.bit_cnt == SAMPLE_BITS - 5'd1) begin
						next_st.cap = CAP_PUSH;
					end
				end
			end
			CAP_PUSH: begin
				// a full buffer holds capture here; bits arriving meanwhile are lost
				if (fifo_in_ready) begin
					next_st.cap = CAP_IDLE;
				end
			end
			default: begin
				next_st.cap = CAP_IDLE;
			end
		endcase

		// per-sample processing
		if (tick) begin
			next_st.out_sample = gained;

			if (st.soft_req && st.soft_att != SOFT_MAX) begin
				next_st.soft_att = st.soft_att + SOFT_STEP;
			end else if (!st.soft_req && st.soft_att != 8'h00) begin
				next_st.soft_att = st.soft_att - SOFT_STEP;
			end

			if (in_sample != 24'h000000) begin
				next_st.zero_cnt = 11'd0;
			end else if (st.zero_cnt != ZERO_RUN_LEN) begin
				next_st.zero_cnt = st.zero_cnt + 11'd1;
			end

			if (!st.limiter_on) begin
				next_st.lim_att  = 6'd0;
				next_st.rate_cnt = 16'h0000;
			end else if (out_mag > upper_th) begin
				next_st.rate_cnt = st.rate_cnt + 16'h0001;
				if (st.rate_cnt + 16'h0001 >= atk_period) begin
					next_st.rate_cnt = 16'h0000;
					if (st.lim_att != LIM_MAX) begin
						next_st.lim_att = st.lim_att + 6'd1;
					end
				end
			end else if (out_mag < lower_th && st.lim_att != 6'd0) begin
				next_st.rate_cnt = st.rate_cnt + 16'h0001;
				if (st.rate_cnt + 16'h0001 >= dcy_period) begin
					next_st.rate_cnt = 16'h0000;
					next_st.lim_att  = st.lim_att - 6'd1;
				end
			end else begin
				// between thresholds gain holds, so quiet input is untouched
				next_st.rate_cnt = 16'h0000;
			end
		end

		next_st.zero_mute = st.zero_en && (next_st.zero_cnt == ZERO_RUN_LEN);

		// modulator runs every clock while powered
		if (st.power_on) begin
			next_st.mod_acc   = mod_sum[19:0];
			next_st.mod_level = mod_sum[24:20];
		end else begin
			next_st.mod_acc    = 20'h00000;
			next_st.mod_level  = 5'h00;
			next_st.out_sample = 24'h000000;
		end
		next_st.active = st.power_on;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st            <= '0;
			st.cap        <= CAP_IDLE;
			st.volume     <= VOLUME_RESET;
			st.decay      <= DECAY_RESET;
			st.attack     <= ATTACK_RESET;
			st.thresh     <= THRESH_RESET;
			st.boost      <= BOOST_RESET;
			st.zero_en    <= 1'b0;
			st.limiter_on <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata        = st.rdata;
	assign modulator_level  = st.mod_level;
	assign zero_run_mute    = st.zero_mute;
	assign converter_active = st.active;

endmodule
`default_nettype wire

// *** hw/dpd_pkg.sv ***
// constants and types shared by the playback digital path
// assumes a single 100 MHz clock and a synchronous active-high reset
package dpd_pkg;

	// ==========================================================
	// register addresses
	localparam logic [6:0] ADDR_POWER3    = 7'h03;
	localparam logic [6:0] ADDR_CONV_CTRL = 7'h0a;
	localparam logic [6:0] ADDR_VOLUME    = 7'h0b;
	localparam logic [6:0] ADDR_LIM_CTRL1 = 7'h18;
	localparam logic [6:0] ADDR_LIM_CTRL2 = 7'h19;
	localparam logic [6:0] ADDR_STATUS    = 7'h1a;

	// ==========================================================
	// field positions
	localparam int POWER_ON_BIT   = 0;
	localparam int SOFT_MUTE_BIT  = 6;
	localparam int ZERO_MUTE_BIT  = 2;
	localparam int PHASE_INV_BIT  = 0;
	localparam int LIMITER_ON_BIT = 8;
	localparam int DECAY_LSB      = 4;
	localparam int ATTACK_LSB     = 0;
	localparam int THRESH_LSB     = 4;
	localparam int BOOST_LSB      = 0;
	localparam int ST_ZERO_BIT    = 0;
	localparam int ST_SOFT_BIT    = 1;
	localparam int ST_LIMIT_BIT   = 2;
	localparam int ST_ACTIVE_BIT  = 3;

	// ==========================================================
	// reset values
	localparam logic [7:0] VOLUME_RESET = 8'hff;
	localparam logic [3:0] DECAY_RESET  = 4'h3;
	localparam logic [3:0] ATTACK_RESET = 4'h2;
	localparam logic [2:0] THRESH_RESET = 3'h0;
	localparam logic [3:0] BOOST_RESET  = 4'h0;

	// ==========================================================
	// data path sizes and counts
	localparam int SAMPLE_W   = 24;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0]  SAMPLE_BITS  = 5'd24;
	localparam logic [10:0] ZERO_RUN_LEN = 11'd1024;
	localparam logic [7:0]  SOFT_MAX     = 8'hff;
	localparam logic [7:0]  SOFT_STEP    = 8'h01;
	localparam logic [5:0]  LIM_MAX      = 6'd48;
	localparam logic [3:0]  BOOST_MAX    = 4'hc;
	localparam logic [3:0]  RATE_CODE_MAX = 4'hb;
	localparam logic [2:0]  THRESH_MAX   = 3'h5;
	localparam logic [10:0] STEPS_PER_6DB = 11'd12;
	localparam int GAIN_FRAC  = 16;
	localparam int BOOST_SHIFT = 2;

	// ==========================================================
	// limiter timing: per-6dB time at code 0, in sample periods (x16) per half-dB
	localparam longint FS_HZ       = 44100;
	localparam longint ATK_6DB_NS  = 94000;
	localparam longint DCY_6DB_NS  = 750000;
	localparam longint NS_PER_S    = 1000000000;
	localparam logic [15:0] ATK_STEP_Q4 =
		16'((ATK_6DB_NS * FS_HZ * 16 + 12 * NS_PER_S - 1) / (12 * NS_PER_S));
	localparam logic [15:0] DCY_STEP_Q4 =
		16'((DCY_6DB_NS * FS_HZ * 16 + 12 * NS_PER_S - 1) / (12 * NS_PER_S));

	// ==========================================================
	// tables: thresholds -0.5 to -6.5 dB of full scale, gain 2^(-k/12) in q16
	localparam logic [6:0][23:0] THRESH_TABLE = {
		24'h3c900c, 24'h43f3bb, 24'h4c3e90, 24'h558c1f,
		24'h5ffc65, 24'h6bb300, 24'h78d6ee};
	localparam logic [11:0][16:0] MANT_TABLE = {
		17'h0879c, 17'h08fad, 17'h09838, 17'h0a145,
		17'h0aadc, 17'h0b505, 17'h0bfc9, 17'h0cb30,
		17'h0d745, 17'h0e412, 17'h0f1a2, 17'h10000};

	// ==========================================================
	// carriers and state
	typedef struct packed {
		logic       write;
		logic [6:0] addr;
		logic [8:0] wdata;
	} dpd_reg_req_s;

	typedef struct packed {
		logic bit_clock;
		logic frame_sync;
		logic data;
	} dpd_serial_s;

	typedef enum logic [1:0] {
		CAP_IDLE  = 2'b00,
		CAP_SHIFT = 2'b01,
		CAP_PUSH  = 2'b11
	} dpd_cap_e;

	typedef struct packed {
		logic [2:0]  bclk_sync;
		logic [2:0]  fs_sync;
		logic [1:0]  data_sync;
		dpd_cap_e    cap;
		logic [4:0]  bit_cnt;
		logic [23:0] shreg;
		logic        power_on;
		logic        soft_req;
		logic        zero_en;
		logic        phase_inv;
		logic [7:0]  volume;
		logic        limiter_on;
		logic [3:0]  decay;
		logic [3:0]  attack;
		logic [2:0]  thresh;
		logic [3:0]  boost;
		logic [7:0]  soft_att;
		logic [5:0]  lim_att;
		logic [15:0] rate_cnt;
		logic [10:0] zero_cnt;
		logic        zero_mute;
		logic [23:0] out_sample;
		logic [19:0] mod_acc;
		logic [4:0]  mod_level;
		logic        active;
		logic [8:0]  rdata;
	} dpd_state_s;

endpackage

// *** hw/dpd_fifo.sv ***
// sample buffer between the serial capture and the filter path
// assumes both sides run on the same clock
`timescale 1ns/1ps
`default_nettype none
module dpd_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} dpd_fifo_s;

	dpd_fifo_s         st;
	dpd_fifo_s         next_st;
	logic [WIDTH-1:0]  mem [DEPTH];
	logic              push;
	logic              pop;

	// ==========================================================
	// flags
	// extra pointer bit tells full from empty without a counter
	assign in_ready  = !(st.wr_ptr[AW] != st.rd_ptr[AW] &&
		st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
	assign out_valid = st.wr_ptr != st.rd_ptr;
	assign out_data  = mem[st.rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// ==========================================================
	// pointers
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr_ptr = st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[st.wr_ptr[AW-1:0]] <= in_data;
		end
	end

endmodule
`default_nettype wire

// *** testbench/dpd_playback_monitor.sv ***
// port assertions for the playback digital path
// assumes it is bound onto dpd_playback, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dpd_playback_monitor
	import dpd_pkg::*;
(
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// register port
	input wire dpd_pkg::dpd_reg_req_s reg_req,
	input wire logic [6:0]            reg_read_addr,
	input wire logic [8:0]            reg_rdata,
	// converter side
	input wire logic [4:0]            modulator_level,
	input wire logic                  zero_run_mute,
	input wire logic                  converter_active
);
	// ====================
	// helpers: power write decode and mirror of the zero-run enable bit
	logic zen;
	logic pwr_wr;
	assign pwr_wr = reg_req.write && reg_req.addr == ADDR_POWER3;
	always_ff @(posedge clk) begin
		if (rst) begin
			zen <= 1'b0;
		end else if (reg_req.write && reg_req.addr == ADDR_CONV_CTRL) begin
			zen <= reg_req.wdata[ZERO_MUTE_BIT];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ====================
	// sequences
	sequence power_wr_s;
		pwr_wr;
	endsequence
	sequence vol_wr_s;
		reg_req.write && reg_req.addr == ADDR_VOLUME && reg_read_addr == ADDR_VOLUME;
	endsequence
	// ====================
	// assertions
	active_follow_a: assert property (power_wr_s |-> ##2
		converter_active == $past(reg_req.wdata[POWER_ON_BIT], 2)) else $error("active lag");
	active_cause_a: assert property ($changed(converter_active) |-> $past(pwr_wr, 2))
		else $error("active moved alone");
	off_silent_a: assert property (!converter_active && !$past(converter_active)
		|-> modulator_level == 5'h00) else $error("level while off");
	level_range_a: assert property (modulator_level <= 5'h10)
		else $error("level out of range");
	reset_quiet_a: assert property ($fell(rst) |-> reg_rdata == 9'h000
		&& modulator_level == 5'h00 && !zero_run_mute && !converter_active)
		else $error("outputs not quiet after reset");
	vol_readback_a: assert property (vol_wr_s ##1 reg_read_addr == ADDR_VOLUME
		|=> reg_rdata[7:0] == $past(reg_req.wdata[7:0], 2)) else $error("volume readback");
	zero_gate_a: assert property (!zen && !$past(zen) |-> !zero_run_mute)
		else $error("mute while disabled");
	zero_enable_a: assert property ($rose(zero_run_mute) |-> zen)
		else $error("mute rose while disabled");
endmodule
bind dpd_playback dpd_playback_monitor i_mon (
	.clk(clk), .rst(rst), .reg_req(reg_req), .reg_read_addr(reg_read_addr),
	.reg_rdata(reg_rdata), .modulator_level(modulator_level),
	.zero_run_mute(zero_run_mute), .converter_active(converter_active));
`default_nettype wire

// *** testbench/dpd_serial_host.sv ***
// serial sample source standing in for the host audio interface
// assumes the bench calls tick and send from falling clock edges
`timescale 1ns/1ps
`default_nettype none
module dpd_serial_host
	import dpd_pkg::*;
(
	// clock
	input  wire logic                clk,
	// serial pins toward the device
	output var dpd_pkg::dpd_serial_s pins
);
	// ====================
	// drivers: bit clock phases of 3 clocks, the sync minimum
	initial begin
		pins = '0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// strobe only; bit clock stays still between frames
	task automatic tick();
		pins.frame_sync = 1'b1;
		hold(4);
		pins.frame_sync = 1'b0;
		hold(6);
	endtask
	// msb first; released line shows the inverse of the last bit
	task automatic send(input logic [23:0] s);
		pins.frame_sync = 1'b1;
		hold(4);
		pins.frame_sync = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			pins.data = s[i];
			hold(3);
			pins.bit_clock = 1'b1;
			hold(3);
			pins.bit_clock = 1'b0;
		end
		pins.data = ~s[0];
		hold(2);
	endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the playback digital path
// assumes the serial host model and the bound port monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dpd_pkg::*;
	// ====================
	// signals
	logic         clk;
	logic         rst;
	dpd_reg_req_s reg_req;
	logic [6:0]   reg_read_addr;
	logic [8:0]   reg_rdata;
	dpd_serial_s  serial_pins;
	logic [4:0]   modulator_level;
	logic         zero_run_mute;
	logic         converter_active;
	int           n_mismatch = 0;
	int           n_compared = 0;
	int           cycles = 0;
	dpd_serial_host i_host (.clk(clk), .pins(serial_pins));
	dpd_playback i_dut (
		.clk(clk), .rst(rst), .reg_req(reg_req), .reg_read_addr(reg_read_addr),
		.reg_rdata(reg_rdata), .serial_pins(serial_pins),
		.modulator_level(modulator_level), .zero_run_mute(zero_run_mute),
		.converter_active(converter_active));
	// ====================
	// shared tasks
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		@(negedge clk);
		reg_req = '{write: 1'b1, addr: a, wdata: d};
		@(negedge clk);
		reg_req.write = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, output logic [8:0] d);
		@(negedge clk);
		reg_read_addr = a;
		repeat (2) @(negedge clk);
		d = reg_rdata;
	endtask
	task automatic st_bit(input int b, input logic e);
		logic [8:0] d;
		rd(ADDR_STATUS, d);
		check({23'h0, d[b]}, {23'h0, e});
	endtask
	task automatic ticks(input int n);
		repeat (n) i_host.tick();
	endtask
	// ====================
	// scenarios
	task automatic t_reset();
		logic [6:0] a [6] = '{ADDR_POWER3, ADDR_CONV_CTRL, ADDR_VOLUME,
			ADDR_LIM_CTRL1, ADDR_LIM_CTRL2, 7'h05};
		logic [8:0] e [6] = '{9'h000, 9'h000, 9'h0ff, 9'h032, 9'h000, 9'h000};
		logic [8:0] d;
		wr(7'h05, 9'h1ff);
		foreach (a[i]) begin
			rd(a[i], d);
			check(24'(d), 24'(e[i]));
		end
		check(24'(converter_active), 24'h0);
	endtask
	task automatic t_regs();
		logic [8:0] d;
		rd(ADDR_VOLUME, d);
		wr(ADDR_VOLUME, 9'h000);
		rd(ADDR_VOLUME, d);
		check(24'(d), 24'h0);
		wr(ADDR_VOLUME, 9'h0ff);
		wr(ADDR_CONV_CTRL, 9'h045);
		rd(ADDR_CONV_CTRL, d);
		check(24'(d), 24'h45);
		wr(ADDR_CONV_CTRL, 9'h000);
	endtask
	task automatic t_power();
		wr(ADDR_POWER3, 9'h001);
		repeat (3) @(negedge clk);
		check(24'(converter_active), 24'h1);
		wr(ADDR_POWER3, 9'h000);
		repeat (3) @(negedge clk);
		check(24'(converter_active), 24'h0);
		check(24'(modulator_level), 24'h0);
		wr(ADDR_POWER3, 9'h001);
	endtask
	// an eighth of full scale keeps every modulator level exact
	task automatic gain_run(input logic [6:0] a, input logic [8:0] d, input logic [4:0] e);
		wr(a, d);
		i_host.send(24'h100000);
		ticks(1);
		check(24'(modulator_level), 24'(e));
	endtask
	task automatic t_gain();
		gain_run(ADDR_CONV_CTRL, 9'h000, 5'd9);
		gain_run(ADDR_CONV_CTRL, 9'h001, 5'd7);
		gain_run(ADDR_CONV_CTRL, 9'h000, 5'd9);
		gain_run(ADDR_LIM_CTRL2, 9'h00c, 5'd12);
		gain_run(ADDR_LIM_CTRL2, 9'h000, 5'd9);
		gain_run(ADDR_VOLUME, 9'h000, 5'd8);
		gain_run(ADDR_VOLUME, 9'h0ff, 5'd9);
	endtask
	// count keeps running while disabled, so enabling mutes at once
	task automatic t_zero();
		ticks(1030);
		check(24'(zero_run_mute), 24'h0);
		wr(ADDR_CONV_CTRL, 9'h004);
		repeat (3) @(negedge clk);
		check(24'(zero_run_mute), 24'h1);
		st_bit(ST_ZERO_BIT, 1'b1);
		i_host.send(24'h000100);
		ticks(1);
		check(24'(zero_run_mute), 24'h0);
		ticks(1023);
		check(24'(zero_run_mute), 24'h0);
		ticks(1);
		check(24'(zero_run_mute), 24'h1);
		wr(ADDR_CONV_CTRL, 9'h000);
	endtask
	task automatic t_soft();
		wr(ADDR_CONV_CTRL, 9'h040);
		ticks(250);
		st_bit(ST_SOFT_BIT, 1'b0);
		ticks(10);
		st_bit(ST_SOFT_BIT, 1'b1);
		wr(ADDR_CONV_CTRL, 9'h000);
		ticks(2);
		st_bit(ST_SOFT_BIT, 1'b0);
		ticks(260);
	endtask
	task automatic lim_run(input logic [8:0] c1, input logic [8:0] c2,
		input logic [23:0] s, input logic e);
		wr(ADDR_LIM_CTRL1, c1);
		wr(ADDR_LIM_CTRL2, c2);
		repeat (4) i_host.send(s);
		ticks(1);
		st_bit(ST_LIMIT_BIT, e);
		ticks(150);
		st_bit(ST_LIMIT_BIT, 1'b0);
	endtask
	task automatic t_limit();
		lim_run(9'h000, 9'h000, 24'h7fffff, 1'b0);
		lim_run(9'h100, 9'h000, 24'h100000, 1'b0);
		lim_run(9'h100, 9'h000, 24'h7fffff, 1'b1);
		lim_run(9'h100, 9'h000, 24'h5a0000, 1'b0);
		lim_run(9'h100, 9'h070, 24'h5a0000, 1'b1);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ====================
	// clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ceiling well above the roughly 38k cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		reg_req = '0;
		reg_read_addr = 7'h00;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset();
		t_regs();
		t_power();
		t_gain();
		t_zero();
		t_soft();
		t_limit();
		print_verdict();
	end
endmodule
`default_nettype wire
